// file: verilog/ext_interrupt_vectoring.sv
/*
 * External pin and pin-change interrupt detection with fixed-priority
 * vectoring of all interrupt sources to the core, registers on APB.
 * Assumes pins are asynchronous; the core pulses vec_ack when it jumps.
 */
`timescale 1ns/1ps
`include "ext_irq_params.svh"

// Function
// - Reset sends execution to address 0x0000.
// - External request at 0x0001, pin change at 0x0002.
// - Timer 1 match A 0x0003, wrap 0x0004, match B 0x0009.
// - Timer 0 wrap 0x0005, match A 0x000A, match B 0x000B.
// - NVM 0x0006, comparator 0x0007, conversion 0x0008, watchdog/serial 0x000C-0x000E.
// - Never-enabled sources never produce a vector fetch.
// - Pins driven as outputs still raise enabled interrupts.
// - Any unmasked pin-change input toggle raises the pin-change request.
// - Pin changes are detected without a clock for wake-up.
// - External pin triggers on any change, fall, rise or held low level.
// - Edges on the external pin are seen only while the clock runs.
// - Low level on the external pin is detected without a clock.
// - Level wake needs level held through start-up, else no interrupt.
// - Sense code 00 low, 01 change, 10 fall, 11 rise.
// - Pin sampled before edge detect; pulses over one clock caught.
// - Edge flag set on trigger, cleared by vector or write-one, zero in level mode.
// - Pin-change flag cleared by vector or write-one; needs enable and global enable.
module ext_interrupt_vectoring
	import ext_irq_pkg::*;
#(
	parameter int PC_WIDTH = 6
) (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                ext_irq_pin,
	input  wire logic [PC_WIDTH-1:0] pin_change_inputs,
	input  wire logic [11:0]         periph_req,
	input  wire logic                global_irq_en,
	input  wire logic                vec_ack,
	output logic                     vec_valid,
	output logic      [3:0]          vec_addr,
	output logic                     wake_async,
	output logic                     irq
);
	// ======================================================================
	// State
	typedef struct packed {
		logic [1:0]          sense;
		logic                ext_en;
		logic                pc_en;
		logic                ext_flag;
		logic                pc_flag;
		logic [PC_WIDTH-1:0] pc_mask;
		logic [PC_WIDTH-1:0] pc_prev;
		logic                ext_prev;
		logic [11:0]         periph_en;
		vec_state_t          vstate;
		logic [3:0]          vaddr;
		logic [1:0]          wake_sts;
		logic [1:0]          wake_msk;
		logic [31:0]         rdata;
		logic [1:0]          warm;
	} state_t;

	state_t      s_r;
	state_t      s_nxt;
	logic        ext_sync;
	logic [PC_WIDTH-1:0] pc_sync;
	sense_mode_t mode;
	logic        ext_edge;
	logic        pc_change;
	logic        level_req;
	logic [13:0] pend;
	logic        wr_ok;
	logic        rd_ok;
	logic        addr_ok;
	logic [3:0]  best;
	logic        any_pend;
	logic        live;

	// ======================================================================
	// Synchronisers
	pin_sync u_ext_sync (
		.clk     (ref_clk),
		.reset_n (reset_n),
		.d       (ext_irq_pin),  // pin read even in output mode
		.q       (ext_sync)
	);

	genvar g;
	generate
		for (g = 0; g < PC_WIDTH; g++) begin : g_pc
			pin_sync u_pc_sync (
				.clk     (ref_clk),
				.reset_n (reset_n),
				.d       (pin_change_inputs[g]),
				.q       (pc_sync[g])
			);
		end
	endgenerate

	// ======================================================================
	// Detection
	assign mode = sense_mode_t'(s_r.sense);

	// Flops reset low while pins may idle high: detect only once synced values settle
	assign live = &s_r.warm;

	always_comb begin
		unique case (mode)
			SENSE_CHANGE: ext_edge = ext_sync ^ s_r.ext_prev;
			SENSE_FALL:   ext_edge = s_r.ext_prev & ~ext_sync;
			SENSE_RISE:   ext_edge = ~s_r.ext_prev & ext_sync;
			SENSE_LOW:    ext_edge = 1'b0;
		endcase
	end

	// Level request lasts as long as the pin is low; drops if released early
	assign level_req = live & (mode == SENSE_LOW) & ~ext_sync;
	assign pc_change = live & |((pc_sync ^ s_r.pc_prev) & s_r.pc_mask);

	// Raw pin terms so a stopped clock still wakes the part
	assign wake_async = live
		& ((s_r.pc_en & |((pin_change_inputs ^ s_r.pc_prev) & s_r.pc_mask))
		| (s_r.ext_en & (mode == SENSE_LOW) & ~ext_irq_pin));

	// ======================================================================
	// Vector selection: only enabled sources pend
	assign pend = {periph_req & s_r.periph_en,
		s_r.pc_flag & s_r.pc_en,
		(s_r.ext_flag | level_req) & s_r.ext_en};

	always_comb begin
		best = 4'h0;
		for (int i = 13; i >= 0; i--) begin
			if (pend[i]) begin
				best = 4'(i + 1);
			end
		end
	end
	assign any_pend = global_irq_en & (|pend);

	// ======================================================================
	// APB
	assign addr_ok = paddr == `OFS_CORE_CONTROL || paddr == `OFS_IRQ_ENABLE
		|| paddr == `OFS_IRQ_FLAGS || paddr == `OFS_PIN_CHANGE_MSK
		|| paddr == `OFS_PERIPH_ENABLE || paddr == `OFS_PERIPH_PENDING
		|| paddr == `OFS_VECTOR_STATUS || paddr == `OFS_WAKE_STATUS
		|| paddr == `OFS_WAKE_MASK;
	assign wr_ok = psel & penable & pwrite & addr_ok;
	assign rd_ok = psel & ~penable & ~pwrite;

	// ======================================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ext_prev = ext_sync;
		s_nxt.pc_prev  = pc_sync;
		s_nxt.warm     = live ? s_r.warm : s_r.warm + 2'h1;

		// Clears first, so a same-cycle event below still sets the flag
		if (wr_ok && paddr == `OFS_IRQ_FLAGS) begin
			if (pwdata[`BIT_EXT_FLAG]) s_nxt.ext_flag = 1'b0;
			if (pwdata[`BIT_PC_FLAG])  s_nxt.pc_flag  = 1'b0;
		end
		if (wr_ok && paddr == `OFS_WAKE_STATUS) begin
			s_nxt.wake_sts = s_r.wake_sts & ~pwdata[1:0];
		end
		if (wr_ok && paddr == `OFS_CORE_CONTROL) s_nxt.sense = pwdata[1:0];
		if (wr_ok && paddr == `OFS_IRQ_ENABLE) begin
			s_nxt.ext_en = pwdata[`BIT_EXT_ENABLE];
			s_nxt.pc_en  = pwdata[`BIT_PC_ENABLE];
		end
		if (wr_ok && paddr == `OFS_PIN_CHANGE_MSK) s_nxt.pc_mask = pwdata[PC_WIDTH-1:0];
		if (wr_ok && paddr == `OFS_PERIPH_ENABLE) s_nxt.periph_en = pwdata[11:0];
		if (wr_ok && paddr == `OFS_WAKE_MASK) s_nxt.wake_msk = pwdata[1:0];

		// Core took the vector: hardware clears the matching flag
		if (s_r.vstate == VEC_ISSUED && vec_ack) begin
			if (s_r.vaddr == `VEC_EXT_IRQ)    s_nxt.ext_flag = 1'b0;
			if (s_r.vaddr == `VEC_PIN_CHANGE) s_nxt.pc_flag  = 1'b0;
		end

		if (ext_edge && live) s_nxt.ext_flag = 1'b1;
		if (pc_change) s_nxt.pc_flag = 1'b1;
		if (s_nxt.sense == SENSE_LOW) s_nxt.ext_flag = 1'b0;
		if (pc_change) s_nxt.wake_sts[`BIT_WAKE_PC] = 1'b1;
		if (level_req) s_nxt.wake_sts[`BIT_WAKE_LEVEL] = 1'b1;

		// Vector handshake; address held until acknowledged
		unique case (s_r.vstate)
			VEC_IDLE: begin
				if (any_pend) begin
					s_nxt.vstate = VEC_ISSUED;
					s_nxt.vaddr  = best;
				end
			end
			VEC_ISSUED: begin
				if (vec_ack) begin
					s_nxt.vstate = VEC_IDLE;
					s_nxt.vaddr  = `VEC_RESET;
				end
			end
		endcase

		s_nxt.rdata = 32'h0;
		if (rd_ok) begin
			unique case (paddr)
				`OFS_CORE_CONTROL:   s_nxt.rdata = {30'h0, s_r.sense};
				`OFS_IRQ_ENABLE:     s_nxt.rdata = {25'h0, s_r.ext_en, s_r.pc_en, 5'h0};
				`OFS_IRQ_FLAGS:      s_nxt.rdata = {25'h0, s_r.ext_flag, s_r.pc_flag, 5'h0};
				`OFS_PIN_CHANGE_MSK: s_nxt.rdata = 32'(s_r.pc_mask);
				`OFS_PERIPH_ENABLE:  s_nxt.rdata = {20'h0, s_r.periph_en};
				`OFS_PERIPH_PENDING: s_nxt.rdata = {18'h0, pend};
				`OFS_VECTOR_STATUS:  s_nxt.rdata = {27'h0, s_r.vstate == VEC_ISSUED, s_r.vaddr};
				`OFS_WAKE_STATUS:    s_nxt.rdata = {30'h0, s_r.wake_sts};
				`OFS_WAKE_MASK:      s_nxt.rdata = {30'h0, s_r.wake_msk};
				default:             s_nxt.rdata = 32'h0;
			endcase
		end
	end

	// ======================================================================
	// Registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_r         <= '0;
			s_r.sense   <= `RST_CORE_CONTROL;
			s_r.pc_mask <= PC_WIDTH'(`RST_PC_MASK);
			s_r.vaddr   <= `VEC_RESET;
			s_r.vstate  <= VEC_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ======================================================================
	// Outputs
	assign prdata    = s_r.rdata;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~addr_ok;
	assign vec_valid = s_r.vstate == VEC_ISSUED;
	assign vec_addr  = s_r.vaddr;
	assign irq       = |(s_r.wake_sts & s_r.wake_msk);
endmodule // ext_interrupt_vectoring

// file: include/ext_irq_params.svh
/*
 * Constants for the external interrupt and vectoring block: register
 * offsets on the APB bus, field positions, reset values and vector addresses.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_CORE_CONTROL   12'h000
`define OFS_IRQ_ENABLE     12'h004
`define OFS_IRQ_FLAGS      12'h008
`define OFS_PIN_CHANGE_MSK 12'h00c
`define OFS_PERIPH_ENABLE  12'h010
`define OFS_PERIPH_PENDING 12'h014
`define OFS_VECTOR_STATUS  12'h018
`define OFS_WAKE_STATUS    12'h01c
`define OFS_WAKE_MASK      12'h020

// ==========================================================================
// Field positions
`define BIT_SENSE_LO       0
`define BIT_SENSE_HI       1
`define BIT_EXT_ENABLE     6
`define BIT_PC_ENABLE      5
`define BIT_EXT_FLAG       6
`define BIT_PC_FLAG        5
`define BIT_WAKE_PC        0
`define BIT_WAKE_LEVEL     1

// ==========================================================================
// Reset values
`define RST_CORE_CONTROL   2'h0
`define RST_PC_MASK        6'h3f

// ==========================================================================
// Vector addresses
`define VEC_RESET          4'h0
`define VEC_EXT_IRQ        4'h1
`define VEC_PIN_CHANGE     4'h2
`define VEC_T1_MATCH_A     4'h3
`define VEC_T1_WRAP        4'h4
`define VEC_T0_WRAP        4'h5
`define VEC_NVM_READY      4'h6
`define VEC_COMPARATOR     4'h7
`define VEC_CONVERSION     4'h8
`define VEC_T1_MATCH_B     4'h9
`define VEC_T0_MATCH_A     4'ha
`define VEC_T0_MATCH_B     4'hb
`define VEC_WATCHDOG       4'hc
`define VEC_SERIAL_START   4'hd
`define VEC_SERIAL_WRAP    4'he

`endif

// file: include/ext_irq_pkg.sv
/*
 * Types shared by the interrupt vectoring block.
 * Assumes nothing of its surroundings.
 */
package ext_irq_pkg;
	typedef enum logic [1:0] {
		SENSE_LOW,
		SENSE_CHANGE,
		SENSE_FALL,
		SENSE_RISE
	} sense_mode_t;

	typedef enum logic {
		VEC_IDLE,
		VEC_ISSUED
	} vec_state_t;
endpackage

// file: verilog/pin_sync.sv
/*
 * Two-stage synchroniser for one level.
 * Assumes d is asynchronous to clk.
 */
`timescale 1ns/1ps

module pin_sync (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic meta;
		logic sync;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt.meta = d;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.sync;
endmodule // pin_sync

// file: test/core_model.sv
/* Core side model: acks each vector offer, promptly or after a delay.
   Assumes offers stand until acked. */
`timescale 1ns/1ps
module core_model (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic slow,
	input  wire logic vec_valid,
	output logic      vec_ack
);
	logic [2:0] wait_r;
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !vec_valid || vec_ack) begin
			wait_r  <= 3'h0;
			vec_ack <= 1'b0;
		end else begin
			wait_r  <= wait_r + 3'h1;
			vec_ack <= (wait_r >= (slow ? 3'h3 : 3'h0));
		end
	end
endmodule // core_model

// file: test/ext_irq_chk.sv
/* Assertions on bus answers and vector offers.
   Assumes binding to the block, seeing only its ports. */
`timescale 1ns/1ps
module ext_irq_chk (
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] periph_req,
	input wire logic        global_irq_en,
	input wire logic        vec_ack,
	input wire logic        vec_valid,
	input wire logic [3:0]  vec_addr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// Vector offer
	sequence offer_s;
		vec_valid && !vec_ack;
	endsequence
	sequence taken_s;
		vec_valid && vec_ack;
	endsequence
	reset_vector_a: assert property ($rose(reset_n) |-> !vec_valid && vec_addr == 4'h0)
		else $error("offer out of reset");
	vec_range_a: assert property (vec_valid |-> vec_addr inside {[4'h1:4'he]})
		else $error("vector out of table");
	offer_hold_a: assert property (offer_s |=> vec_valid && $stable(vec_addr))
		else $error("offer dropped before ack");
	ack_idle_a: assert property (taken_s |=> !vec_valid)
		else $error("no idle after ack");
	gie_gate_a: assert property ($rose(vec_valid) |-> $past(global_irq_en))
		else $error("offer while globally off");
	src_request_a: assert property ($rose(vec_valid) && vec_addr > 4'h2 |->
		((($past(periph_req) | $past(periph_req, 2)) >> (vec_addr - 4'h3)) & 12'h1) != 12'h0)
		else $error("offer without request");
	// ==========================================
	// Bus answers
	ready_high_a: assert property (psel && penable |-> pready)
		else $error("pready low");
	bad_addr_a: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
		else $error("unmapped not refused");
	rdata_idle_a: assert property (!(psel && !penable && !pwrite) |=> prdata == 32'h0)
		else $error("prdata not cleared");
endmodule // ext_irq_chk

bind ext_interrupt_vectoring ext_irq_chk u_ext_irq_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .periph_req(periph_req),
	.global_irq_en(global_irq_en), .vec_ack(vec_ack), .vec_valid(vec_valid),
	.vec_addr(vec_addr));

// file: test/tb_top.sv
/* Bench: APB tasks and vector offer tests.
   Assumes the core model acks every offer. */
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module tb_top;
	logic        ref_clk, reset_n, psel, penable, pwrite, pin, gie, slow, vec_ack;
	logic        pready, pslverr, vec_valid, wake_async, irq, err;
	logic [11:0] paddr, req;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  pcin;
	logic [3:0]  vec_addr;
	int          num_errors, cmp_count;
	localparam logic [3:0] STEPS [6] = '{4'h9, 4'ha, 4'hc, 4'hf, 4'h5, 4'h7};

	ext_interrupt_vectoring u_ext_interrupt_vectoring (.ref_clk(ref_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(pin),
		.pin_change_inputs(pcin), .periph_req(req), .global_irq_en(gie), .vec_ack(vec_ack),
		.vec_valid(vec_valid), .vec_addr(vec_addr), .wake_async(wake_async), .irq(irq));
	core_model u_core_model (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
		.vec_valid(vec_valid), .vec_ack(vec_ack));

	// ==========================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d = 32'h0);
		@(posedge ref_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic expect_vec(input logic fire, input logic [3:0] exp, input logic rel = 1'b0);
		int n;
		n = 0;
		while (fire && vec_valid !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		if (!fire) repeat (20) @(posedge ref_clk);
		check({vec_valid, vec_addr}, {fire, exp});
		req <= 12'h0;
		if (rel) pin <= 1'b1;
		while (vec_valid === 1'b1) @(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		check(vec_valid, 1'b0);
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================
	// Clock, watchdog, tests
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		stop_test();
	end
	initial begin
		{reset_n, psel, penable, pwrite, slow} = '0;
		{paddr, pwdata, req, pcin} = '0;
		{pin, gie} = 2'b11;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check(vec_addr, 4'h0);
		apb(1'b0, `OFS_PIN_CHANGE_MSK);
		check(rd, 32'h3f);
		apb(1'b0, 12'h040);
		check(err, 1'b1);
		check(rd, 32'h0);
		apb(1'b1, `OFS_PERIPH_ENABLE, 32'hfff);
		for (int i = 0; i < 12; i++) begin
			slow <= i[0];
			req <= 12'h1 << i;
			expect_vec(1'b1, 4'h3 + 4'(i));
		end
		req <= 12'hfff;
		expect_vec(1'b1, 4'h3);
		apb(1'b1, `OFS_PERIPH_ENABLE, 32'hffe);
		req <= 12'h1;
		expect_vec(1'b0, 4'h0);
		apb(1'b1, `OFS_IRQ_ENABLE, 32'h60);
		for (int s = 0; s < 6; s++) begin
			apb(1'b1, `OFS_CORE_CONTROL, {30'h0, STEPS[s][3:2]});
			pin <= STEPS[s][1];
			expect_vec(STEPS[s][0], {3'h0, STEPS[s][0]});
		end
		// Held off globally while the edge flag is read; slow acks so the level term is gone before the gap after ack
		gie <= 1'b0;
		slow <= 1'b1;
		pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		apb(1'b0, `OFS_IRQ_FLAGS);
		check(rd, 32'h40);
		apb(1'b1, `OFS_CORE_CONTROL, 32'h0);
		apb(1'b0, `OFS_IRQ_FLAGS);
		check(rd, 32'h0);
		check(wake_async, 1'b1);
		gie <= 1'b1;
		expect_vec(1'b1, 4'h1, 1'b1);
		// Level gone before the core may take it: no vector
		gie <= 1'b0;
		pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		gie <= 1'b1;
		expect_vec(1'b0, 4'h0);
		apb(1'b1, `OFS_PIN_CHANGE_MSK, 32'h1);
		pcin <= 6'h2;
		@(posedge ref_clk);
		check(wake_async, 1'b0);
		expect_vec(1'b0, 4'h0);
		pcin <= 6'h3;
		@(posedge ref_clk);
		check(wake_async, 1'b1);
		expect_vec(1'b1, 4'h2);
		apb(1'b1, `OFS_WAKE_MASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		check(irq, 1'b1);
		apb(1'b1, `OFS_WAKE_MASK, 32'h0);
		repeat (2) @(posedge ref_clk);
		check(irq, 1'b0);
		apb(1'b1, `OFS_WAKE_STATUS, 32'h3);
		apb(1'b1, `OFS_WAKE_MASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		check(irq, 1'b0);
		gie <= 1'b0;
		pcin <= 6'h2;
		expect_vec(1'b0, 4'h0);
		apb(1'b0, `OFS_IRQ_FLAGS);
		check(rd, 32'h20);
		apb(1'b1, `OFS_IRQ_FLAGS, 32'h20);
		apb(1'b0, `OFS_IRQ_FLAGS);
		check(rd, 32'h0);
		stop_test();
	end
endmodule // tb_top
